//--- logic/cod_pkg.sv
// Constants, field layouts and carrier types of the configuration option decoder
`default_nettype none
package cod_pkg;
   // ====================================================
   // Stored byte defaults and reserved masks
   localparam logic [7:0] CFG_ERASED     = 8'hFF;
   localparam logic [7:0] LOADER_RSVD    = 8'hF8;
   localparam logic [7:0] BROWNOUT_RSVD  = 8'h43;
   localparam logic [7:0] WDOG_RSVD      = 8'h0F;
   // ====================================================
   // Field positions
   localparam int LOADER_SIZE_LSB = 0;
   localparam int BO_ON_BIT    = 7;
   localparam int BO_LVL_LSB   = 4;
   localparam int BO_INH_BIT   = 3;
   localparam int BO_RST_BIT   = 2;
   localparam int WD_LSB       = 4;
   // ====================================================
   // Encodings
   localparam logic [3:0] WD_GP_TIMER   = 4'hF;
   localparam logic [3:0] WD_STOP_IDLE  = 4'h5;
   localparam logic [1:0] SEL_LOADER    = 2'h0;
   localparam logic [1:0] SEL_BROWNOUT  = 2'h1;
   localparam logic [1:0] SEL_WDOG      = 2'h2;
   // ====================================================
   // Link framing: read flag, select, one spare bit, data byte
   localparam int          FRAME_BITS = 12;
   localparam int          DATA_BITS  = 8;
   localparam logic [3:0]  FRAME_LAST = 4'hB;
   localparam logic [3:0]  DATA_LAST  = 4'h7;

   typedef enum logic [1:0] {
      COD_WD_GP_TIMER = 2'b00,
      COD_WD_RST_STOP = 2'b01,
      COD_WD_RST_RUN  = 2'b10
   } cod_wd_e;

   typedef enum logic [1:0] {
      COD_LNK_HDR  = 2'b00,
      COD_LNK_WAIT = 2'b01,
      COD_LNK_SEND = 2'b10
   } cod_lnk_e;

   typedef struct packed {
      logic [2:0] loaderKb;
      logic [4:0] appKb;
   } cod_region_s;

   typedef struct packed {
      logic       on;
      logic [1:0] level;
      logic       inhibit;
      logic       rstOn;
   } cod_bo_s;
endpackage : cod_pkg
`default_nettype wire

//--- logic/cod_config_decoder.sv
// Configuration byte store, option decode and programming-port link
// ====================================================
`timescale 1ns/1ps
`default_nettype none
module cod_config_decoder (
   input  wire logic            core_clk,
   input  wire logic            rst,
   input  wire logic            sysRst,
   input  wire logic            rstPinN,
   input  wire logic            progClk,
   input  wire logic            pdaIn,
   output logic                 pdaOut,
   output logic                 pdaOe,
   input  wire logic            brownoutLow,
   input  wire logic            swBoWrite,
   input  wire cod_pkg::cod_bo_s swBo,
   output cod_pkg::cod_region_s region,
   output cod_pkg::cod_bo_s     boRt,
   output cod_pkg::cod_wd_e     wdMode,
   output logic                 selfProgBlock,
   output logic                 bodResetReq,
   output logic                 progMode
);
   // ====================================================
   // Decode helpers
   function automatic cod_pkg::cod_region_s decodeRegion(input logic [2:0] sz);
      cod_pkg::cod_region_s r;
      r = '{loaderKb: 3'h4, appKb: 5'h0E};
      case (sz)
         3'b111: r = '{loaderKb: 3'h0, appKb: 5'h12};
         3'b110: r = '{loaderKb: 3'h1, appKb: 5'h11};
         3'b101: r = '{loaderKb: 3'h2, appKb: 5'h10};
         3'b100: r = '{loaderKb: 3'h3, appKb: 5'h0F};
         default: r = '{loaderKb: 3'h4, appKb: 5'h0E};
      endcase
      return r;
   endfunction

   function automatic cod_pkg::cod_wd_e decodeWd(input logic [3:0] pol);
      cod_pkg::cod_wd_e m;
      if (pol == cod_pkg::WD_GP_TIMER) begin
         m = cod_pkg::COD_WD_GP_TIMER;
      end else if (pol == cod_pkg::WD_STOP_IDLE) begin
         m = cod_pkg::COD_WD_RST_STOP;
      end else begin
         m = cod_pkg::COD_WD_RST_RUN;
      end
      return m;
   endfunction

   function automatic cod_pkg::cod_bo_s decodeBo(input logic [7:0] b);
      cod_pkg::cod_bo_s s;
      s.on      = b[cod_pkg::BO_ON_BIT];
      s.level   = b[cod_pkg::BO_LVL_LSB +: 2];
      s.inhibit = b[cod_pkg::BO_INH_BIT];
      s.rstOn   = b[cod_pkg::BO_RST_BIT];
      return s;
   endfunction

   // ====================================================
   // Core-domain storage and synchronisers
   logic [7:0] cfgLoader;
   logic [7:0] cfgBrown;
   logic [7:0] cfgWdog;
   logic [1:0] pinSync;
   logic [1:0] lowSync;
   logic [2:0] wrReqSync;
   logic [1:0] rdReqSync;
   logic       rdAck;
   logic [7:0] rdData;

   // Link-domain state
   logic [1:0]           progLinkSync;
   logic                 wrReq;
   logic                 rdReq;
   logic [1:0]           rdAckSync;
   logic                 rdAckSeen;
   logic [11:0]          shiftIn;
   logic [11:0]          frameWord;
   logic [3:0]           bitCnt;
   logic [7:0]           shiftOut;
   cod_pkg::cod_lnk_e    lnkState;
   logic                 linkRst;

   always_ff @(posedge core_clk) begin
      pinSync   <= {pinSync[0], rstPinN};
      lowSync   <= {lowSync[0], brownoutLow};
      wrReqSync <= {wrReqSync[1:0], wrReq};
      rdReqSync <= {rdReqSync[0], rdReq};
   end

   // Pin low moves the port into programming mode; high releases it
   always_ff @(posedge core_clk) begin
      if (rst) begin
         progMode <= 1'b0;
      end else begin
         progMode <= ~pinSync[1];
      end
   end

   // Byte store: writes arrive from the link as a toggle, word held stable
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cfgLoader <= cod_pkg::CFG_ERASED;
         cfgBrown  <= cod_pkg::CFG_ERASED;
         cfgWdog   <= cod_pkg::CFG_ERASED;
      end else if (wrReqSync[2] != wrReqSync[1]) begin
         // Reserved positions are forced high whatever the programmer sends
         case (frameWord[10:9])
            cod_pkg::SEL_LOADER:   cfgLoader <= frameWord[7:0] | cod_pkg::LOADER_RSVD;
            cod_pkg::SEL_BROWNOUT: cfgBrown  <= frameWord[7:0] | cod_pkg::BROWNOUT_RSVD;
            cod_pkg::SEL_WDOG:     cfgWdog   <= frameWord[7:0] | cod_pkg::WDOG_RSVD;
            default: ;
         endcase
      end
   end

   // Read handshake: data is latched on the same edge that toggles the acknowledge
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rdAck  <= 1'b0;
         rdData <= cod_pkg::CFG_ERASED;
      end else if (rdReqSync[1] != rdAck) begin
         rdAck <= rdReqSync[1];
         case (frameWord[10:9])
            cod_pkg::SEL_LOADER:   rdData <= cfgLoader;
            cod_pkg::SEL_BROWNOUT: rdData <= cfgBrown;
            cod_pkg::SEL_WDOG:     rdData <= cfgWdog;
            default:               rdData <= cod_pkg::CFG_ERASED;
         endcase
      end
   end

   // ====================================================
   // Runtime option copies
   // Region and watchdog reload on every reset
   always_ff @(posedge core_clk) begin
      if (rst) begin
         region <= decodeRegion(cod_pkg::CFG_ERASED[2:0]);
         wdMode <= decodeWd(cod_pkg::CFG_ERASED[7:4]);
      end else if (sysRst) begin
         region <= decodeRegion(cfgLoader[cod_pkg::LOADER_SIZE_LSB +: 3]);
         wdMode <= decodeWd(cfgWdog[cod_pkg::WD_LSB +: 4]);
      end
   end

   // Brown-out copy reloads only at power-on; software may change it later
   always_ff @(posedge core_clk) begin
      if (rst) begin
         boRt <= decodeBo(cfgBrown);
      end else if (swBoWrite) begin
         boRt <= swBo;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         selfProgBlock <= 1'b0;
         bodResetReq   <= 1'b0;
      end else begin
         selfProgBlock <= boRt.on & boRt.inhibit & lowSync[1];
         bodResetReq <= boRt.on & boRt.rstOn & lowSync[1];
      end
   end

   // ====================================================
   // Link domain on the programming clock
   // The clock stops outside sessions, so leaving the mode resets the link
   always_ff @(posedge progClk) begin
      progLinkSync <= {progLinkSync[0], ~rstPinN};
      rdAckSync   <= {rdAckSync[0], rdAck};
   end
   assign linkRst = ~progLinkSync[1];

   // Requests cross as toggles; a session must end after an even number of each,
   // or the cleared toggle looks like one more request to the core

   always_ff @(posedge progClk) begin
      if (linkRst) begin
         lnkState  <= cod_pkg::COD_LNK_HDR;
         bitCnt    <= 4'h0;
         shiftIn   <= 12'h000;
         frameWord <= 12'h000;
         shiftOut  <= 8'h00;
         wrReq     <= 1'b0;
         rdReq     <= 1'b0;
         rdAckSeen <= 1'b0;
         pdaOut    <= 1'b0;
         pdaOe     <= 1'b0;
      end else begin
         case (lnkState)
            cod_pkg::COD_LNK_HDR: begin
               shiftIn <= {shiftIn[10:0], pdaIn};
               pdaOe   <= 1'b0;
               if (bitCnt == cod_pkg::FRAME_LAST) begin
                  bitCnt    <= 4'h0;
                  frameWord <= {shiftIn[10:0], pdaIn};
                  if (shiftIn[10]) begin
                     rdReq    <= ~rdReq;
                     lnkState <= cod_pkg::COD_LNK_WAIT;
                  end else begin
                     wrReq <= ~wrReq;
                  end
               end else begin
                  bitCnt <= bitCnt + 4'h1;
               end
            end
            cod_pkg::COD_LNK_WAIT: begin
               if (rdAckSync[1] != rdAckSeen) begin
                  rdAckSeen <= rdAckSync[1];
                  shiftOut  <= {rdData[6:0], 1'b0};
                  pdaOut    <= rdData[7];
                  pdaOe     <= 1'b1;
                  lnkState  <= cod_pkg::COD_LNK_SEND;
               end
            end
            cod_pkg::COD_LNK_SEND: begin
               if (bitCnt == cod_pkg::DATA_LAST) begin
                  bitCnt   <= 4'h0;
                  pdaOe    <= 1'b0;
                  lnkState <= cod_pkg::COD_LNK_HDR;
               end else begin
                  bitCnt   <= bitCnt + 4'h1;
                  pdaOut   <= shiftOut[7];
                  shiftOut <= {shiftOut[6:0], 1'b0};
               end
            end
            default: lnkState <= cod_pkg::COD_LNK_HDR;
         endcase
      end
   end

   // ====================================================
   // Checks
   AST_POR_DEFAULT: assert property (@(posedge core_clk) rst |=>
      cfgLoader == 8'hFF && cfgBrown == 8'hFF && cfgWdog == 8'hFF)
      else $error("Bytes not erased after power-on reset");
   AST_REGION: assert property (@(posedge core_clk) disable iff (rst) sysRst |=>
      region == decodeRegion($past(cfgLoader[2:0])))
      else $error("Region split does not match loader size");
   AST_BO_POR: assert property (@(posedge core_clk) rst ##1 !rst |->
      boRt.on == cfgBrown[7] && boRt.level == cfgBrown[5:4] && boRt.inhibit == cfgBrown[3]
      && boRt.rstOn == cfgBrown[2])
      else $error("Brown-out copy not loaded at power-on");
   AST_BO_HOLD: assert property (@(posedge core_clk) disable iff (rst) sysRst && !swBoWrite |=>
      boRt == $past(boRt))
      else $error("Brown-out copy reloaded by a non power-on reset");
   AST_SELFPROG_OFF: assert property (@(posedge core_clk) disable iff (rst)
      !boRt.on [*2] |-> !selfProgBlock)
      else $error("Self-programming blocked with detection off");
   AST_SELFPROG_ON: assert property (@(posedge core_clk) disable iff (rst)
      (boRt.on && boRt.inhibit) [*4] ##0 $past(lowSync[1]) |-> selfProgBlock)
      else $error("Self-programming not blocked below threshold");
   AST_BO_RST: assert property (@(posedge core_clk) disable iff (rst) bodResetReq |-> $past(boRt.rstOn))
      else $error("Brown-out reset raised while disabled");
   AST_WD_GP: assert property (@(posedge core_clk) disable iff (rst)
      sysRst && cfgWdog[7:4] == 4'hF |=> wdMode == cod_pkg::COD_WD_GP_TIMER)
      else $error("Watchdog not left as plain timer");
   AST_WD_STOP: assert property (@(posedge core_clk) disable iff (rst)
      sysRst && cfgWdog[7:4] == 4'h5 |=> wdMode == cod_pkg::COD_WD_RST_STOP)
      else $error("Watchdog not halting in low power");
   AST_WD_RUN: assert property (@(posedge core_clk) disable iff (rst)
      sysRst && cfgWdog[7:4] != 4'hF && cfgWdog[7:4] != 4'h5 |=> wdMode == cod_pkg::COD_WD_RST_RUN)
      else $error("Watchdog not running through low power");
   AST_RSVD: assert property (@(posedge core_clk) disable iff (rst)
      (cfgBrown & 8'h43) == 8'h43 && (cfgLoader & 8'hF8) == 8'hF8 && (cfgWdog & 8'h0F) == 8'h0F)
      else $error("Reserved bit stored as zero");
   AST_PDA_OE: assert property (@(posedge progClk) disable iff (linkRst)
      pdaOe |-> lnkState == cod_pkg::COD_LNK_SEND)
      else $error("Data pin driven outside a read reply");
   AST_REPLY_LEN: assert property (@(posedge progClk) disable iff (linkRst)
      $rose(pdaOe) |-> pdaOe [*8] ##1 !pdaOe)
      else $error("Read reply not eight clocks long");
   AST_PROG_MODE: assert property (@(posedge core_clk) disable iff (rst)
      $fell(pinSync[1]) |=> progMode)
      else $error("Programming mode not entered on low reset pin");
   AST_BO_SW: assert property (@(posedge core_clk) disable iff (rst)
      swBoWrite |=> boRt == $past(swBo))
      else $error("Software write not taken by brown-out copy");

   COV_WRITE: cover property (@(posedge core_clk) wrReqSync[2] != wrReqSync[1]);
   COV_READ:  cover property (@(posedge progClk) $rose(pdaOe));
   COV_SELFPROG: cover property (@(posedge core_clk) $rose(selfProgBlock));
   COV_BORST: cover property (@(posedge core_clk) $rose(bodResetReq));
   COV_MODE:  cover property (@(posedge core_clk) $rose(progMode));
endmodule // cod_config_decoder
`default_nettype wire

//--- verification/cod_prog_model.sv
// Behavioural in-circuit programmer driving the programming pins
`timescale 1ns/1ps
`default_nettype none
module cod_prog_model (
   output logic      progClk,
   output logic      rstPinN,
   output logic      pdaIn,
   input  wire logic pdaOut,
   input  wire logic pdaOe
);
   logic drv = 1'b0;
   logic drvOn = 1'b1;

   // Released line has no pull: show the inverse of the last bit so stale data never passes
   assign pdaIn = pdaOe ? pdaOut : (drvOn ? drv : ~drv);

   initial begin
      progClk = 1'b0;
      rstPinN = 1'b1;
   end

   // ====================================================
   // Clock runs only while a task ticks it, 6 ns period
   task automatic edgeHi;
      #3 progClk = 1'b1;
      #1;
   endtask
   task automatic edgeLo;
      #2 progClk = 1'b0;
   endtask
   task automatic tick;
      edgeHi();
      edgeLo();
   endtask
   task automatic linkInit;
      repeat (4) tick();
   endtask
   task automatic enter;
      rstPinN = 1'b0;
      repeat (2) tick();
   endtask
   task automatic leave;
      rstPinN = 1'b1;
      repeat (3) tick();
   endtask

   // ====================================================
   // Frames: read flag, select, spare, data byte, MSB first
   task automatic send(input logic [11:0] f);
      for (int i = 11; i >= 0; i--) begin
         drv = f[i];
         tick();
      end
   endtask
   task automatic writeCfg(input logic [1:0] sel, input logic [7:0] d);
      send({1'b0, sel, 1'b1, d});
      // Clock stands still while the core takes the byte; extra edges would start a frame
      #48;
   endtask
   task automatic readCfg(input logic [1:0] sel, output logic [7:0] d);
      int n;
      d = 'x;
      n = 0;
      send({1'b1, sel, 1'b1, 8'hFF});
      drvOn = 1'b0;
      edgeHi();
      while (pdaOe !== 1'b1 && n < 30) begin
         edgeLo();
         edgeHi();
         n++;
      end
      for (int i = 7; i >= 0; i--) begin
         d[i] = pdaOut;
         edgeLo();
         edgeHi();
      end
      edgeLo();
      drvOn = 1'b1;
   endtask
endmodule // cod_prog_model
`default_nettype wire

//--- verification/cod_config_decoder_tb_top.sv
// Self-checking testbench of the configuration option decoder
`timescale 1ns/1ps
`default_nettype none
module cod_config_decoder_tb_top;
   logic                 core_clk = 1'b0;
   logic                 rst = 1'b1;
   logic                 sysRst = 1'b0;
   logic                 brownoutLow = 1'b0;
   logic                 swBoWrite = 1'b0;
   cod_pkg::cod_bo_s     swBo = '0;
   wire logic            rstPinN, progClk, pdaIn, pdaOut, pdaOe;
   cod_pkg::cod_region_s region;
   cod_pkg::cod_bo_s     boRt;
   cod_pkg::cod_wd_e     wdMode;
   logic                 selfProgBlock, bodResetReq, progMode;
   int                   badCount = 0;
   int                   checked = 0;
   logic [7:0]           rd;
   logic [2:0]           ldExp;
   logic [1:0]           wdExp;
   logic [2:0]           ldCode [6] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h0};

   always #4 core_clk = ~core_clk;

   cod_config_decoder DUT (.core_clk(core_clk), .rst(rst), .sysRst(sysRst), .rstPinN(rstPinN),
      .progClk(progClk), .pdaIn(pdaIn), .pdaOut(pdaOut), .pdaOe(pdaOe), .brownoutLow(brownoutLow),
      .swBoWrite(swBoWrite), .swBo(swBo), .region(region), .boRt(boRt), .wdMode(wdMode),
      .selfProgBlock(selfProgBlock), .bodResetReq(bodResetReq), .progMode(progMode));
   cod_prog_model prog (.progClk(progClk), .rstPinN(rstPinN), .pdaIn(pdaIn), .pdaOut(pdaOut), .pdaOe(pdaOe));

   // ====================================================
   // Shared tasks
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         badCount++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic endOfTest;
      $display("comparisons %0d mismatches %0d", checked, badCount);
      if (badCount == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Decoded fields only follow the store at a reset edge
   task automatic sysPulse;
      @(negedge core_clk) sysRst = 1'b1;
      @(negedge core_clk) sysRst = 1'b0;
      repeat (2) @(negedge core_clk);
   endtask

   initial begin
      #200000;
      badCount++;
      endOfTest();
   end

   // ====================================================
   // Test sequence
   initial begin
      repeat (8) @(negedge core_clk);
      rst = 1'b0;
      prog.linkInit();
      repeat (2) @(negedge core_clk);
      check(region, 8'h12);
      check({6'h00, wdMode}, 8'h00);
      check({3'h0, boRt}, 8'h1F);
      check({5'h00, selfProgBlock, bodResetReq, progMode}, 8'h00);
      $display("test defaults done");
      prog.enter();
      repeat (4) @(negedge core_clk);
      check({7'h00, progMode}, 8'h01);
      for (int s = 0; s < 4; s++) begin
         prog.readCfg(2'(s), rd);
         check(rd, 8'hFF);
      end
      $display("test readback done");
      foreach (ldCode[i]) begin
         prog.writeCfg(cod_pkg::SEL_LOADER, {5'h1F, ldCode[i]});
         sysPulse();
         ldExp = ldCode[i][2] ? 3'h7 - ldCode[i] : 3'h4;
         check(region, {ldExp, 5'h12 - {2'h0, ldExp}});
      end
      prog.writeCfg(cod_pkg::SEL_LOADER, 8'h02);
      prog.readCfg(cod_pkg::SEL_LOADER, rd);
      check(rd, 8'hFA);
      sysPulse();
      check(region, {3'h4, 5'h0E});
      $display("test loader done");
      for (int p = 0; p < 16; p++) begin
         prog.writeCfg(cod_pkg::SEL_WDOG, {4'(p), 4'hF});
         sysPulse();
         wdExp = (p == 15) ? 2'h0 : (p == 5) ? 2'h1 : 2'h2;
         check({6'h00, wdMode}, {6'h00, wdExp});
      end
      prog.writeCfg(cod_pkg::SEL_BROWNOUT, 8'h00);
      prog.readCfg(cod_pkg::SEL_BROWNOUT, rd);
      check(rd, 8'h43);
      $display("test watchdog done");
      // Counting down leaves the runtime copy at zero, equal to its reload value from the stored 43 byte
      for (int v = 63; v >= 0; v--) begin
         @(negedge core_clk);
         swBo = 5'(v);
         swBoWrite = 1'b1;
         brownoutLow = v[5];
         @(negedge core_clk);
         swBoWrite = 1'b0;
         repeat (4) @(negedge core_clk);
         check({3'h0, boRt}, {3'h0, 5'(v)});
         check({6'h00, selfProgBlock, bodResetReq}, {6'h00, v[4] & v[1] & v[5], v[4] & v[0] & v[5]});
      end
      // A later system reset must leave the software copy alone
      @(negedge core_clk) swBo = 5'h15;
      swBoWrite = 1'b1;
      @(negedge core_clk) swBoWrite = 1'b0;
      sysPulse();
      check({3'h0, boRt}, 8'h15);
      $display("test brownout done");
      prog.leave();
      repeat (4) @(negedge core_clk);
      check({7'h00, progMode}, 8'h00);
      @(negedge core_clk) rst = 1'b1;
      repeat (2) @(negedge core_clk);
      rst = 1'b0;
      repeat (2) @(negedge core_clk);
      check({3'h0, boRt}, 8'h1F);
      check(region, 8'h12);
      $display("test power-on reload done");
      endOfTest();
   end
endmodule // cod_config_decoder_tb_top
`default_nettype wire
